// File: design/sqp_consts.svh
// constants of the preset / test-array sequencer core
// assumes a single 10 MHz clock and an active-low asynchronous power-up reset
// Notes on behaviour
// RQ1: product lines 48 and 49 form a factory test array usable before programming.
// RQ2: the programmer deletes test lines 48 and 49 for user logic.
// RQ3: tester loops outputs to upper inputs, grounds preset pin, applies stimulus.
// RQ4: power up forces every state and output flip-flop high.
// RQ5: preset pin high blocks clocking and forces all register bits high.
// RQ6: no falling clock edge needed after preset; only short inactive setup.
// RQ7: the first rising edge after any preset loads next state and outputs; the code loads on the third edge after the preset pin falls (two-stage sync).
// RQ8: system waits the setup interval after power-up before the first clock.
// RQ9: six state bits fed back plus eight registered outputs, rising-edge Mealy.
// RQ10: dual-purpose pin presets registers, or with fuse blown controls outputs.
// RQ11: output-control mode: low enables outputs, high floats them, contents kept.
`ifndef SQP_CONSTS_SVH
`define SQP_CONSTS_SVH

`define SQP_N_IN 16
`define SQP_N_STATE 6
`define SQP_N_OUT 8
`define SQP_N_BITS 14
`define SQP_N_PT 48
`define SQP_N_VARS 22
`define SQP_N_SYNC 19
`define SQP_PRESET_VAL 14'h3fff
`define SQP_OE_ON 8'hff
`define SQP_OE_OFF 8'h00
`define SQP_SYNC_RST 19'h0_0000
`define SQP_CLK_PERIOD_NS 100
`define SQP_PRESET_SETUP_NS 8
`define SQP_PRESET_SETUP_CYC \
    (((`SQP_PRESET_SETUP_NS + `SQP_CLK_PERIOD_NS - 1) / `SQP_CLK_PERIOD_NS) < 1 ? 1 : \
    ((`SQP_PRESET_SETUP_NS + `SQP_CLK_PERIOD_NS - 1) / `SQP_CLK_PERIOD_NS))

`endif

// File: design/sqp_pkg.sv
// types shared by the sequencer core
// assumes sqp_consts.svh is on the include path
`include "sqp_consts.svh"
package sqp_pkg;
    typedef struct packed {
        logic [`SQP_N_STATE-1:0] state;
        logic [`SQP_N_OUT-1:0] outs;
    } sqp_regs_t;

    typedef struct packed {
        logic cfg_test_array;
        logic cfg_output_control;
        logic preset_oc;
        logic [`SQP_N_OUT-1:0] upper;
        logic [`SQP_N_OUT-1:0] lower;
    } sqp_pins_t;
endpackage

// File: design/sqp_sequencer.sv
// programmable mealy sequencer with preset recovery and factory test array
// assumes all pins are asynchronous to REF_CLK; fuse map arrives as parameters
`include "sqp_consts.svh"
module sqp_sequencer
    import sqp_pkg::*;
#(
    // intact fuse = 1; an all-intact product line never fires
    parameter logic [`SQP_N_PT*`SQP_N_VARS-1:0] PT_TRUE = '1,
    parameter logic [`SQP_N_PT*`SQP_N_VARS-1:0] PT_COMP = '1,
    parameter logic [`SQP_N_BITS*`SQP_N_PT-1:0] OR_SET = '1,
    parameter logic [`SQP_N_BITS*`SQP_N_PT-1:0] OR_RST = '1
) (
    // clock and power-up reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // logic inputs
    input wire logic [`SQP_N_OUT-1:0] LOWER_INPUTS,
    input wire logic [`SQP_N_OUT-1:0] UPPER_INPUTS,
    // dual-purpose pin and configuration fuses
    input wire logic PRESET_OC,
    input wire logic CFG_OUTPUT_CONTROL,
    input wire logic CFG_TEST_ARRAY,
    // registered outputs
    output logic [`SQP_N_OUT-1:0] REGISTERED_OUTPUTS,
    output logic [`SQP_N_OUT-1:0] REGISTERED_OUTPUTS_OE
);

    sqp_pins_t pins_raw;
    sqp_pins_t sync1;
    sqp_pins_t sync2;
    sqp_regs_t regs;
    sqp_regs_t next_regs;
    logic [`SQP_N_OUT-1:0] next_oe;
    logic [`SQP_N_OUT-1:0] oe;
    wire [`SQP_N_VARS-1:0] vars;
    wire [`SQP_N_PT-1:0] pt;
    wire [1:0] test_pt;
    wire [`SQP_N_BITS-1:0] set_sum;
    wire [`SQP_N_BITS-1:0] rst_sum;
    wire [`SQP_N_BITS-1:0] next_bits;
    wire preset_act;
    wire oc_off;

    // s/r flip-flop: both asserted holds, a conservative stand-in for undefined
    function automatic logic sr_next(input logic s, input logic r, input logic q);
        sr_next = (s & ~r) | (q & ~(r & ~s));
    endfunction

    assign pins_raw = '{cfg_test_array: CFG_TEST_ARRAY,
                        cfg_output_control: CFG_OUTPUT_CONTROL,
                        preset_oc: PRESET_OC,
                        upper: UPPER_INPUTS,
                        lower: LOWER_INPUTS};

    // two-stage synchroniser for every pin
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1 <= `SQP_SYNC_RST;
            sync2 <= `SQP_SYNC_RST;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
        end
    end

    // product array sees inputs and fed-back state bits
    assign vars = {regs.state, sync2.upper, sync2.lower}; // RQ9 RQ3

    genvar p;
    generate
        for (p = 0; p < `SQP_N_PT; p = p + 1) begin : g_pt
            assign pt[p] = (&(~PT_TRUE[p*`SQP_N_VARS +: `SQP_N_VARS] | vars)) &
                           (&(~PT_COMP[p*`SQP_N_VARS +: `SQP_N_VARS] | ~vars));
        end
    endgenerate

    // test lines 48 (all high) and 49 (all low); fuse clear means deleted
    assign test_pt[0] = sync2.cfg_test_array & (&vars); // RQ1 RQ2
    assign test_pt[1] = sync2.cfg_test_array & ~(|vars); // RQ1 RQ2

    genvar b;
    generate
        for (b = 0; b < `SQP_N_BITS; b = b + 1) begin : g_bit
            assign set_sum[b] = (|(pt & OR_SET[b*`SQP_N_PT +: `SQP_N_PT])) | test_pt[1];
            assign rst_sum[b] = (|(pt & OR_RST[b*`SQP_N_PT +: `SQP_N_PT])) | test_pt[0];
            assign next_bits[b] = sr_next(set_sum[b], rst_sum[b], regs[b]);
        end
    endgenerate

    always_comb begin
        next_regs = next_bits;
    end

    // the pin means preset unless the output-control fuse is blown
    assign preset_act = ~sync2.cfg_output_control & sync2.preset_oc; // RQ10 RQ5
    assign oc_off = sync2.cfg_output_control & sync2.preset_oc; // RQ10 RQ11

    always_comb begin
        next_oe = oc_off ? `SQP_OE_OFF : `SQP_OE_ON; // RQ11
    end

    // no recovery gap: first edge with preset clear loads the next state
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            regs <= `SQP_PRESET_VAL; // RQ4
        end else if (preset_act) begin
            regs <= `SQP_PRESET_VAL; // RQ5
        end else begin
            regs <= next_regs; // RQ6 RQ7 RQ9
        end
    end

    // outputs float during power-up reset; the first edge after release enables them from the cleared sync2, before the pin arrives
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            oe <= `SQP_OE_OFF;
        end else begin
            oe <= next_oe;
        end
    end

    assign REGISTERED_OUTPUTS = regs.outs;
    assign REGISTERED_OUTPUTS_OE = oe;

    sequence s_preset_release;
        preset_act ##1 !preset_act;
    endsequence

    sequence s_oc_float;
        oc_off ##1 oc_off;
    endsequence

    property p_preset_high;
        @(posedge REF_CLK) disable iff (!RESETN)
        preset_act |=> (regs == `SQP_PRESET_VAL);
    endproperty
    a_preset_high: assert property (p_preset_high) // RQ5
        else $error("preset did not force registers high");

    property p_first_edge_loads;
        @(posedge REF_CLK) disable iff (!RESETN)
        s_preset_release |=> (regs == $past(next_regs));
    endproperty
    a_first_edge_loads: assert property (p_first_edge_loads) // RQ7
        else $error("first edge after preset did not load next state");

    property p_no_fall_needed;
        @(posedge REF_CLK) disable iff (!RESETN)
        (!preset_act && $past(preset_act)) |=> (regs == $past(next_regs));
    endproperty
    a_no_fall_needed: assert property (p_no_fall_needed) // RQ6
        else $error("clocking did not resume at once after preset");

    // sampled reset: the release edge itself still loads reset values
    property p_mealy_update;
        @(posedge REF_CLK) disable iff (!RESETN)
        (RESETN && !preset_act) |=> (REGISTERED_OUTPUTS == $past(next_regs.outs)) &&
                        (regs.state == $past(next_regs.state));
    endproperty
    a_mealy_update: assert property (p_mealy_update) // RQ9
        else $error("state or outputs failed to follow next value");

    property p_oc_float;
        @(posedge REF_CLK) disable iff (!RESETN)
        s_oc_float |=> (REGISTERED_OUTPUTS_OE == `SQP_OE_OFF) &&
                       (regs == $past(next_regs));
    endproperty
    a_oc_float: assert property (p_oc_float) // RQ11
        else $error("output control high did not float outputs or disturbed state");

    property p_oc_enable;
        @(posedge REF_CLK) disable iff (!RESETN)
        (sync2.cfg_output_control && !sync2.preset_oc) |=>
            (REGISTERED_OUTPUTS_OE == `SQP_OE_ON);
    endproperty
    a_oc_enable: assert property (p_oc_enable) // RQ11
        else $error("output control low did not enable outputs");

    property p_preset_mode_driven;
        @(posedge REF_CLK) disable iff (!RESETN)
        (RESETN && !sync2.cfg_output_control) |=> (REGISTERED_OUTPUTS_OE == `SQP_OE_ON);
    endproperty
    a_preset_mode_driven: assert property (p_preset_mode_driven) // RQ10
        else $error("outputs floated in preset configuration");

    property p_test_low_sets;
        @(posedge REF_CLK) disable iff (!RESETN)
        (sync2.cfg_test_array && (vars == '0) && (rst_sum == '0) && !preset_act)
            |=> (regs == `SQP_PRESET_VAL);
    endproperty
    a_test_low_sets: assert property (p_test_low_sets) // RQ1
        else $error("test line 49 did not set all bits");

    property p_test_deleted;
        @(posedge REF_CLK) disable iff (!RESETN)
        !sync2.cfg_test_array |-> (test_pt == 2'h0);
    endproperty
    a_test_deleted: assert property (p_test_deleted) // RQ2
        else $error("deleted test lines still active");

    property p_powerup_high;
        @(posedge REF_CLK)
        (RESETN && !$past(RESETN)) |-> (regs == `SQP_PRESET_VAL);
    endproperty
    a_powerup_high: assert property (p_powerup_high) // RQ4
        else $error("registers not high after power-up");

endmodule

// File: tb/sqp_tester.sv
// tester model: loops the registered outputs back to the upper inputs
// assumes the sequencer's outputs and output enables are wired to it
`include "sqp_consts.svh"
module sqp_tester (
    // clock and loop control
    input wire logic clk,
    input wire logic loop_en,
    // device side
    input wire logic [`SQP_N_OUT-1:0] q,
    input wire logic [`SQP_N_OUT-1:0] q_oe,
    output logic [`SQP_N_OUT-1:0] upper
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`SQP_N_OUT-1:0] last = 8'hff;
    // a floated output keeps no level, so the loop sees its inverse
    always_ff @(posedge clk) if (q_oe == `SQP_OE_ON) last <= q;
    assign upper = !loop_en ? 8'h00 : (q_oe == `SQP_OE_ON) ? q : ~last;
endmodule

// File: tb/tb.sv
// bench for the sequencer: test array, preset recovery, output control
// assumes the factory test array intact and the outputs looped back
`include "sqp_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0;
    logic resetn = 0;
    logic preset_oc = 0;
    logic cfg_oc = 0;
    logic cfg_test = 1;
    logic loop_en = 1;
    logic [7:0] lower = 8'h00;
    logic [7:0] upper, q, q_oe;
    int n_mismatch = 0;
    int n_tests = 0;
    always #50 ref_clk = ~ref_clk;
    sqp_sequencer sqp_sequencer_i (.REF_CLK(ref_clk), .RESETN(resetn),
        .LOWER_INPUTS(lower), .UPPER_INPUTS(upper), .PRESET_OC(preset_oc),
        .CFG_OUTPUT_CONTROL(cfg_oc), .CFG_TEST_ARRAY(cfg_test),
        .REGISTERED_OUTPUTS(q), .REGISTERED_OUTPUTS_OE(q_oe));
    sqp_tester sqp_tester_i (.clk(ref_clk), .loop_en(loop_en), .q(q), .q_oe(q_oe),
        .upper(upper));
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // settle past the edge so its updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_q(input logic [7:0] exp, input int lim);
        for (int i = 0; i < lim && q !== exp; i++) cyc(1);
        chk("outputs after wait", exp, q);
        if (q !== exp) final_report();
    endtask
    task automatic t_test_array;
        @(posedge ref_clk) lower <= 8'hff;
        wait_q(8'h00, 8);
        @(posedge ref_clk) lower <= 8'h00;
        wait_q(8'hff, 8);
        $display("test array done");
    endtask
    task automatic t_preset;
        @(posedge ref_clk) lower <= 8'hff;
        wait_q(8'h00, 8);
        @(posedge ref_clk) preset_oc <= 1'b1;
        cyc(3);
        chk("outputs in preset", 8'hff, q);
        cyc(4);
        chk("outputs held in preset", 8'hff, q);
        @(posedge ref_clk) preset_oc <= 1'b0;
        cyc(2);
        chk("outputs before load", 8'hff, q);
        cyc(1);
        chk("first edge loads", 8'h00, q);
        $display("preset recovery done");
    endtask
    // all-low inputs would set every bit if line 49 were still present
    task automatic t_deleted;
        @(posedge ref_clk) begin
            cfg_test <= 1'b0;
            lower <= 8'h00;
        end
        cyc(6);
        chk("outputs with test lines deleted", 8'h00, q);
        @(posedge ref_clk) begin
            cfg_test <= 1'b1;
            lower <= 8'hff;
        end
        cyc(4);
        chk("outputs after test lines restored", 8'h00, q);
        $display("test line deletion done");
    endtask
    task automatic t_out_ctl;
        @(posedge ref_clk) cfg_oc <= 1'b1;
        cyc(3);
        @(posedge ref_clk) preset_oc <= 1'b1;
        cyc(3);
        chk("enable off", `SQP_OE_OFF, q_oe);
        cyc(4);
        chk("contents kept", 8'h00, q);
        @(posedge ref_clk) preset_oc <= 1'b0;
        cyc(3);
        chk("enable on", `SQP_OE_ON, q_oe);
        chk("contents after enable", 8'h00, q);
        $display("output control done");
    endtask
    task automatic t_reset_mid;
        @(posedge ref_clk) resetn <= 1'b0;
        cyc(1);
        chk("outputs in reset", 8'hff, q);
        chk("enable in reset", `SQP_OE_OFF, q_oe);
        @(posedge ref_clk) resetn <= 1'b1;
        cyc(2);
        chk("enable after second reset", `SQP_OE_ON, q_oe);
        chk("outputs after second reset", 8'hff, q);
        $display("second reset done");
    endtask
    initial begin
        cyc(3);
        chk("outputs at power up", 8'hff, q);
        chk("enable at power up", `SQP_OE_OFF, q_oe);
        @(posedge ref_clk) resetn <= 1'b1;
        cyc(4);
        chk("enable after reset", `SQP_OE_ON, q_oe);
        t_test_array();
        t_preset();
        t_deleted();
        t_out_ctl();
        t_reset_mid();
        final_report();
    end
endmodule
